// ===== design/ppl_pkg.sv
// Purpose: constants and types for the two-channel position preset and latch block
// Assumes: 32-bit AHB-Lite register access, one clock
// Notes: byte offsets within a channel window; channel n window at (n - 1) * PPL_CH_STRIDE
package ppl_pkg;
   // channel register offsets (addr[5:0])
   localparam logic [5:0] PPL_OFF_CTRL = 6'h00;
   localparam logic [5:0] PPL_OFF_PRESET = 6'h04;
   localparam logic [5:0] PPL_OFF_CFG = 6'h08;
   localparam logic [5:0] PPL_OFF_STATUS = 6'h0C;
   localparam logic [5:0] PPL_OFF_POS = 6'h10;
   localparam logic [5:0] PPL_OFF_LATCH = 6'h14;
   localparam logic [5:0] PPL_OFF_OFFSET = 6'h18;
   localparam logic [5:0] PPL_OFF_TS_LO = 6'h1C;
   localparam logic [5:0] PPL_OFF_TS_HI = 6'h20;
   localparam logic [7:0] PPL_CH_STRIDE = 8'h40;
   // global registers
   localparam logic [7:0] PPL_ADDR_CMD = 8'h80;
   localparam logic [7:0] PPL_ADDR_MODE = 8'h84;
   // control bits
   localparam int PPL_CTRL_SW = 0;
   localparam int PPL_CTRL_EDGE = 1;
   localparam int PPL_CTRL_LATCH = 2;
   // config fields
   localparam int PPL_CFG_POL_LSB = 0;
   localparam int PPL_CFG_CONT = 2;
   // status bits
   localparam int PPL_ST_UNDER = 0;
   localparam int PPL_ST_OVER = 1;
   localparam int PPL_ST_DIN = 2;
   localparam int PPL_ST_DONE = 3;
   localparam int PPL_ST_VALID = 4;
   // edge polarity codes
   localparam logic [1:0] PPL_POL_OFF = 2'b00;
   localparam logic [1:0] PPL_POL_RISE = 2'b10;
   localparam logic [1:0] PPL_POL_FALL = 2'b11;
   // offset clear commands
   localparam logic [15:0] PPL_CMD_CLR_ALL = 16'h8010;
   localparam logic [15:0] PPL_CMD_CLR_CH1 = 16'h8011;
   localparam logic [15:0] PPL_CMD_CLR_CH2 = 16'h8012;
   // position limits on the widened sum and on the 32-bit position
   localparam logic signed [32:0] PPL_SUM_MIN = 33'h1_8000_0000;
   localparam logic signed [32:0] PPL_SUM_MAX = 33'h0_7FFF_FFFF;
   localparam logic [31:0] PPL_POS_MIN = 32'h8000_0000;
   localparam logic [31:0] PPL_POS_MAX = 32'h7FFF_FFFF;
   // reset values
   localparam logic PPL_RST_READY = 1'b1;
   localparam logic PPL_RST_RESP = 1'b0;

   typedef logic [1:0][31:0] ppl_pos_pair_t;

   typedef struct packed {
      logic sw_req;
      logic edge_req;
      logic latch_req;
      logic [31:0] preset;
      logic [1:0] pol;
      logic cont;
      logic sw_arm;
      logic edge_arm;
      logic latch_arm;
      logic done;
      logic valid;
      logic under;
      logic over;
      logic [31:0] pos;
      logic [31:0] latch;
      logic [31:0] offset;
      logic [63:0] ts;
      logic [2:0] din_sync;
   } ppl_ch_t;

   typedef struct packed {
      logic pend;
      logic wr;
      logic [7:0] addr;
      logic ready;
      logic resp;
      logic [31:0] rdata;
   } ppl_bus_t;

   typedef struct packed {
      ppl_ch_t [1:0] ch;
      ppl_bus_t bus;
      logic synced_capture_opmode;
   } ppl_state_t;
endpackage

// ===== design/ppl_position_preset_and_latch.sv
// Purpose: two-channel position preset, offset keeping and edge latch with timestamp
// Assumes: AHB-Lite slave, single word transfers, one wait state per access
// Notes: raw position and system time are inputs from the surrounding device
//
// How it works
// - software preset request loads the preset value into the position.
// - done flag goes TRUE after any preset, software or edge.
// - a held software or non-continuous edge preset request does nothing until it has been seen low.
// - polarity 0 disables, 10 selects rising, 11 selects falling edge.
// - edge preset request loads preset on first selected input edge.
// - non-continuous: later edges ignored; new preset only while done is FALSE.
// - continuous: preset at every selected edge, done set per edge and held until a status read.
// - present level of the digital input is reported as a status bit.
// - one polarity and one continuous setting serve both preset and latch.
// - every preset stores the resulting offset in a per-channel offset register.
// - commands 0x8010, 0x8011, 0x8012 clear offsets of both, channel 1, channel 2.
// - latch request copies position into latch register on first selected edge.
// - latch-valid flag goes TRUE after a capture.
// - latch request must drop low before another capture can be armed.
// - non-continuous: later edges leave latch alone; capture only while valid FALSE.
// - continuous: capture at every selected edge, valid set per edge and held until a status read.
// - capture happens on the controller cycle of the synchronised edge, not at the edge itself.
// - each channel holds a 64-bit timestamp of its latched position.
// - timestamp is system time of the last rising edge that captured.
// - position is signed 32-bit; reaching a limit flags and freezes it.
`timescale 1ns/100ps
module ppl_position_preset_and_latch
   import ppl_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [1:0] din,
   input wire ppl_pos_pair_t raw_pos,
   input wire logic [63:0] sys_time
);

   ppl_state_t s_q;
   ppl_state_t s_d;
   ppl_ch_t cq;
   ppl_ch_t cd;
   logic wr_hit;
   logic rd_hit;
   logic ch_hit;
   logic [5:0] off;
   logic rise;
   logic fall;
   logic edge_ev;
   logic do_sw;
   logic do_edge;
   logic do_latch;
   logic clr_off;
   logic st_read;
   logic signed [32:0] sum;
   logic [31:0] rd;

   assign hrdata = s_q.bus.rdata;
   assign hreadyout = s_q.bus.ready;
   assign hresp = s_q.bus.resp;

   always_comb begin
      s_d = s_q;
      cq = '0;
      cd = '0;
      ch_hit = 1'b0;
      rise = 1'b0;
      fall = 1'b0;
      edge_ev = 1'b0;
      do_sw = 1'b0;
      do_edge = 1'b0;
      do_latch = 1'b0;
      clr_off = 1'b0;
      st_read = 1'b0;
      sum = '0;
      rd = '0;
      off = s_q.bus.addr[5:0];
      wr_hit = s_q.bus.pend & s_q.bus.wr;
      rd_hit = s_q.bus.pend & ~s_q.bus.wr;

      // address phase: one wait state so read data leaves a flip-flop
      s_d.bus.pend = 1'b0;
      s_d.bus.ready = 1'b1;
      s_d.bus.resp = PPL_RST_RESP;
      if (hsel && htrans[1] && hready) begin
         s_d.bus.pend = 1'b1;
         s_d.bus.wr = hwrite;
         s_d.bus.addr = haddr[7:0];
         s_d.bus.ready = 1'b0;
      end

      if (wr_hit && s_q.bus.addr == PPL_ADDR_MODE) begin
         s_d.synced_capture_opmode = hwdata[0];
      end

      for (int c = 0; c < 2; c++) begin
         // each channel sees only its own input, requests and settings
         cq = s_q.ch[c];
         cd = cq;
         ch_hit = (s_q.bus.addr[7:6] == 2'(c));

         cd.din_sync = {cq.din_sync[1:0], din[c]};
         rise = cq.din_sync[1] & ~cq.din_sync[2];
         fall = ~cq.din_sync[1] & cq.din_sync[2];
         edge_ev = ((cq.pol == PPL_POL_RISE) & rise) | ((cq.pol == PPL_POL_FALL) & fall);

         // request bits must be seen low before they arm again
         if (!cq.sw_req) begin
            cd.sw_arm = 1'b1;
         end
         if (!cq.edge_req) begin
            cd.edge_arm = 1'b1;
         end
         if (!cq.latch_req) begin
            cd.latch_arm = 1'b1;
         end

         do_sw = cq.sw_req & cq.sw_arm;
         do_edge = cq.edge_req & edge_ev & (cq.cont | (cq.edge_arm & ~cq.done));
         do_latch = cq.latch_req & edge_ev & (cq.cont | (cq.latch_arm & ~cq.valid));
         if (do_sw) begin
            cd.sw_arm = 1'b0;
         end
         if (do_edge) begin
            cd.edge_arm = 1'b0;
         end
         if (do_latch) begin
            cd.latch_arm = 1'b0;
         end

         st_read = rd_hit & ch_hit & (off == PPL_OFF_STATUS);

         // flags: held while requested, or one status read per edge when continuous
         if (cq.cont ? st_read : (!cq.sw_req && !cq.edge_req)) begin
            cd.done = 1'b0;
         end
         if (cq.cont ? st_read : !cq.latch_req) begin
            cd.valid = 1'b0;
         end
         if (do_sw || do_edge) begin
            cd.done = 1'b1;
         end
         if (do_latch) begin
            cd.valid = 1'b1;
         end

         clr_off = wr_hit && s_q.bus.addr == PPL_ADDR_CMD &&
                   (hwdata[15:0] == PPL_CMD_CLR_ALL ||
                    hwdata[15:0] == (c == 0 ? PPL_CMD_CLR_CH1 : PPL_CMD_CLR_CH2));

         // widened sum so the limit test cannot wrap
         sum = {raw_pos[c][31], raw_pos[c]} + {cq.offset[31], cq.offset};
         if (do_sw || do_edge) begin
            cd.offset = cq.preset - raw_pos[c];
            cd.pos = cq.preset;
            cd.under = 1'b0;
            cd.over = 1'b0;
         end else begin
            if (clr_off) begin
               cd.offset = '0;
               cd.under = 1'b0;
               cd.over = 1'b0;
            end
            // once a limit is reached the value stays frozen until an offset clear or a preset
            if (!(cq.under || cq.over) || clr_off) begin
               if (sum <= PPL_SUM_MIN) begin
                  cd.pos = PPL_POS_MIN;
                  cd.under = 1'b1;
               end else if (sum >= PPL_SUM_MAX) begin
                  cd.pos = PPL_POS_MAX;
                  cd.over = 1'b1;
               end else begin
                  cd.pos = sum[31:0];
               end
            end
         end

         // capture on the synchronised edge cycle itself
         if (do_latch) begin
            cd.latch = cq.pos;
            if (rise && s_q.synced_capture_opmode) begin
               cd.ts = sys_time;
            end
         end

         if (wr_hit && ch_hit) begin
            unique case (off)
               PPL_OFF_CTRL: begin
                  cd.sw_req = hwdata[PPL_CTRL_SW];
                  cd.edge_req = hwdata[PPL_CTRL_EDGE];
                  cd.latch_req = hwdata[PPL_CTRL_LATCH];
               end
               PPL_OFF_PRESET: begin
                  cd.preset = hwdata;
               end
               PPL_OFF_CFG: begin
                  cd.pol = hwdata[PPL_CFG_POL_LSB +: 2];
                  cd.cont = hwdata[PPL_CFG_CONT];
               end
               default: begin
               end
            endcase
         end

         if (rd_hit && ch_hit) begin
            unique case (off)
               PPL_OFF_CTRL: begin
                  rd[PPL_CTRL_SW] = cq.sw_req;
                  rd[PPL_CTRL_EDGE] = cq.edge_req;
                  rd[PPL_CTRL_LATCH] = cq.latch_req;
               end
               PPL_OFF_PRESET: begin
                  rd = cq.preset;
               end
               PPL_OFF_CFG: begin
                  rd[PPL_CFG_POL_LSB +: 2] = cq.pol;
                  rd[PPL_CFG_CONT] = cq.cont;
               end
               PPL_OFF_STATUS: begin
                  rd[PPL_ST_UNDER] = cq.under;
                  rd[PPL_ST_OVER] = cq.over;
                  rd[PPL_ST_DIN] = cq.din_sync[1];
                  rd[PPL_ST_DONE] = cq.done;
                  rd[PPL_ST_VALID] = cq.valid;
               end
               PPL_OFF_POS: begin
                  rd = cq.pos;
               end
               PPL_OFF_LATCH: begin
                  rd = cq.latch;
               end
               PPL_OFF_OFFSET: begin
                  rd = cq.offset;
               end
               PPL_OFF_TS_LO: begin
                  rd = cq.ts[31:0];
               end
               PPL_OFF_TS_HI: begin
                  rd = cq.ts[63:32];
               end
               default: begin
               end
            endcase
         end

         s_d.ch[c] = cd;
      end

      // the timestamp halves are two reads; a capture between them tears the pair
      if (rd_hit && s_q.bus.addr == PPL_ADDR_MODE) begin
         rd[0] = s_q.synced_capture_opmode;
      end
      // read data stands until the next read, so a late sample still sees it
      if (rd_hit) begin
         s_d.bus.rdata = rd;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s_q <= '0;
         s_q.bus.ready <= PPL_RST_READY;
      end else begin
         s_q <= s_d;
      end
   end

endmodule

// ===== dv/ppl_monitor.sv
// Purpose: bus timing and status read checks for the preset and latch block
// Assumes: one slave, hready equals hreadyout
// Notes: read data is seen two edges after the address edge
`timescale 1ns/100ps
module ppl_monitor
   import ppl_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [1:0] din
);
   logic tk;
   logic rd;
   logic [2:0] quiet_q;
   assign tk = hsel && htrans[1] && hready;
   assign rd = tk && !hwrite;
   // din must be quiet for a while, else the sync delay races the status read
   always_ff @(posedge clk) begin
      if (!reset_n || $changed(din[0])) begin
         quiet_q <= 3'h0;
      end else if (quiet_q != 3'h7) begin
         quiet_q <= quiet_q + 3'h1;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   bus_okay_a: assert property (hresp == 1'b0) else $error("hresp not okay");
   one_wait_a: assert property (tk |=> !hreadyout ##1 hreadyout) else $error("wait state wrong");
   idle_ready_a: assert property (!tk |=> hreadyout) else $error("ready low without access");
   fell_cause_a: assert property ($fell(hreadyout) |-> $past(tk)) else $error("ready fell alone");
   rdata_hold_a: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
      else $error("hrdata moved");
   din_level_a: assert property (
      rd && haddr[7:0] == 8'h0C && quiet_q >= 3'h4
      |=> ##1 hrdata[PPL_ST_DIN] == $past(din[0], 2)) else $error("din level wrong");
   range_excl_a: assert property (
      rd && haddr[7:0] == 8'h0C |=> ##1 !(hrdata[0] && hrdata[1])) else $error("both limits");
   zero_read_a: assert property (
      rd && (haddr[7:0] == PPL_ADDR_CMD || haddr[7:0] == 8'hF0)
      |=> ##1 hrdata == 32'h0000_0000) else $error("read not zero");
endmodule

// ===== dv/ppl_sensor_model.sv
// Purpose: digital edge sensor, raw position and system time source
// Assumes: bench calls the tasks just after a rising edge
// Notes: time is set, not free running, so each stamp is known exactly
`timescale 1ns/100ps
module ppl_sensor_model
   import ppl_pkg::*;
(
   output logic [1:0] din,
   output ppl_pos_pair_t raw_pos,
   output logic [63:0] sys_time
);
   initial begin
      din = 2'b00;
      raw_pos = '0;
      sys_time = 64'h0000_0000_0000_0000;
   end
   task automatic set_din(input logic v);
      din[0] <= v;
   endtask
   task automatic set_pos(input int ch, input logic [31:0] v);
      raw_pos[ch] <= v;
   endtask
   task automatic set_time(input logic [63:0] t);
      sys_time <= t;
   endtask
endmodule

// ===== dv/ppl_position_preset_and_latch_tb_top.sv
// Purpose: directed bench for the position preset and latch block
// Assumes: one AHB-Lite master, sensor model on channel 1 input
// Notes: edge waits cover two sync stages plus one update
`timescale 1ns/100ps
module ppl_position_preset_and_latch_tb_top;
   import ppl_pkg::*;
   localparam logic [1:0] C1 = 2'b00;
   localparam logic [1:0] C2 = 2'b01;
   localparam logic [1:0] GL = 2'b10;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic [1:0] din;
   ppl_pos_pair_t raw_pos;
   logic [63:0] sys_time;
   logic [31:0] p;
   int miscompares = 0;
   int num_checks = 0;
   always #25 clk = ~clk;
   ppl_position_preset_and_latch DUT (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .din(din), .raw_pos(raw_pos),
      .sys_time(sys_time));
   ppl_sensor_model sen (.din(din), .raw_pos(raw_pos), .sys_time(sys_time));
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h00_0000, a};
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      q = hrdata;
   endtask
   task automatic wr(input logic [1:0] c, input logic [5:0] o, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, {c, o}, d, x);
   endtask
   task automatic chk(input logic [1:0] c, input logic [5:0] o, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, {c, o}, 32'h0000_0000, q);
      num_checks++;
      if (q !== e) begin
         miscompares++;
         $display("mismatch reg %h exp %h got %h", {c, o}, e, q);
      end
   endtask
   task automatic pulse(input logic v);
      sen.set_din(v);
      repeat (5) @(posedge clk);
   endtask
   task automatic t_reset;
      chk(C1, PPL_OFF_CFG, 32'h0000_0000);
      chk(C2, PPL_OFF_STATUS, 32'h0000_0000);
      wr(2'b11, 6'h30, 32'hFFFF_FFFF);
      chk(2'b11, 6'h30, 32'h0000_0000);
      chk(GL, 6'h00, 32'h0000_0000);
      $display("test reset done");
   endtask
   task automatic t_sw;
      sen.set_pos(0, 32'h0000_0100);
      wr(C1, PPL_OFF_PRESET, 32'h0000_1000);
      wr(C1, PPL_OFF_CTRL, 32'h0000_0001);
      chk(C1, PPL_OFF_POS, 32'h0000_1000);
      chk(C1, PPL_OFF_OFFSET, 32'h0000_0F00);
      chk(C1, PPL_OFF_STATUS, 32'h0000_0008);
      wr(C1, PPL_OFF_PRESET, 32'h0000_2000);
      chk(C1, PPL_OFF_POS, 32'h0000_1000);
      wr(C1, PPL_OFF_CTRL, 32'h0000_0000);
      wr(C1, PPL_OFF_CTRL, 32'h0000_0001);
      chk(C1, PPL_OFF_POS, 32'h0000_2000);
      $display("test software preset done");
   endtask
   task automatic t_cmd;
      logic [15:0] cmd [3] = '{PPL_CMD_CLR_ALL, PPL_CMD_CLR_CH1, PPL_CMD_CLR_CH2};
      sen.set_pos(1, 32'h0000_0200);
      for (int i = 0; i < 3; i++) begin
         for (int c = 0; c < 2; c++) begin
            wr(2'(c), PPL_OFF_PRESET, 32'h0000_1000);
            wr(2'(c), PPL_OFF_CTRL, 32'h0000_0000);
            wr(2'(c), PPL_OFF_CTRL, 32'h0000_0001);
         end
         wr(GL, 6'h00, {16'h0000, cmd[i]});
         chk(C1, PPL_OFF_OFFSET, (i == 2) ? 32'h0000_0F00 : 32'h0000_0000);
         chk(C2, PPL_OFF_OFFSET, (i == 1) ? 32'h0000_0E00 : 32'h0000_0000);
      end
      $display("test offset clear done");
   endtask
   task automatic t_limit;
      wr(C2, PPL_OFF_PRESET, 32'h7FFF_FFF0);
      wr(C2, PPL_OFF_CTRL, 32'h0000_0000);
      wr(C2, PPL_OFF_CTRL, 32'h0000_0001);
      sen.set_pos(1, 32'h0000_0300);
      chk(C2, PPL_OFF_POS, 32'h7FFF_FFFF);
      chk(C2, PPL_OFF_STATUS, 32'h0000_000A);
      sen.set_pos(1, 32'h0000_0200);
      chk(C2, PPL_OFF_POS, 32'h7FFF_FFFF);
      wr(GL, 6'h00, {16'h0000, PPL_CMD_CLR_CH2});
      chk(C2, PPL_OFF_POS, 32'h0000_0200);
      chk(C2, PPL_OFF_STATUS, 32'h0000_0008);
      chk(C1, PPL_OFF_OFFSET, 32'h0000_0F00);
      $display("test position limit done");
   endtask
   task automatic t_edge;
      logic [1:0] pol [3] = '{PPL_POL_OFF, PPL_POL_RISE, PPL_POL_FALL};
      p = 32'h0000_1000;
      for (int i = 0; i < 3; i++) begin
         wr(C1, PPL_OFF_CTRL, 32'h0000_0000);
         wr(C1, PPL_OFF_PRESET, 32'h0000_3000 + 32'(i));
         wr(C1, PPL_OFF_CFG, {30'h0, pol[i]});
         wr(C1, PPL_OFF_CTRL, 32'h0000_0002);
         pulse(1'b1);
         if (i == 1) p = 32'h0000_3001;
         chk(C1, PPL_OFF_POS, p);
         pulse(1'b0);
         if (i == 2) p = 32'h0000_3002;
         chk(C1, PPL_OFF_POS, p);
      end
      wr(C1, PPL_OFF_PRESET, 32'h0000_4000);
      pulse(1'b1);
      pulse(1'b0);
      chk(C1, PPL_OFF_POS, p);
      chk(C1, PPL_OFF_STATUS, 32'h0000_0008);
      $display("test edge preset done");
   endtask
   task automatic t_latch;
      wr(GL, 6'h04, 32'h0000_0001);
      wr(C1, PPL_OFF_CTRL, 32'h0000_0000);
      wr(C1, PPL_OFF_CFG, 32'h0000_0002);
      wr(C1, PPL_OFF_CTRL, 32'h0000_0004);
      sen.set_time(64'h0123_4567_89AB_CDEF);
      pulse(1'b1);
      chk(C1, PPL_OFF_LATCH, p);
      chk(C1, PPL_OFF_STATUS, 32'h0000_0014);
      chk(C1, PPL_OFF_TS_LO, 32'h89AB_CDEF);
      chk(C1, PPL_OFF_TS_HI, 32'h0123_4567);
      sen.set_pos(0, 32'h0000_0900);
      pulse(1'b0);
      pulse(1'b1);
      chk(C1, PPL_OFF_LATCH, p);
      wr(C1, PPL_OFF_CFG, 32'h0000_0007);
      sen.set_time(64'h0000_0000_0000_0042);
      pulse(1'b0);
      chk(C1, PPL_OFF_LATCH, p + 32'h0000_0800);
      chk(C1, PPL_OFF_STATUS, 32'h0000_0010);
      chk(C1, PPL_OFF_STATUS, 32'h0000_0000);
      chk(C1, PPL_OFF_TS_LO, 32'h89AB_CDEF);
      $display("test latch done");
   endtask
   task automatic t_cont;
      wr(C1, PPL_OFF_CTRL, 32'h0000_0002);
      wr(C1, PPL_OFF_PRESET, 32'h0000_5000);
      pulse(1'b1);
      pulse(1'b0);
      chk(C1, PPL_OFF_POS, 32'h0000_5000);
      wr(C1, PPL_OFF_PRESET, 32'h0000_6000);
      pulse(1'b1);
      pulse(1'b0);
      chk(C1, PPL_OFF_POS, 32'h0000_6000);
      chk(C1, PPL_OFF_STATUS, 32'h0000_0008);
      chk(C1, PPL_OFF_STATUS, 32'h0000_0000);
      $display("test continuous preset done");
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      #400_000;
      miscompares++;
      finish_test();
   end
   initial begin
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      t_reset();
      t_sw();
      t_cmd();
      t_limit();
      t_edge();
      t_latch();
      t_cont();
      finish_test();
   end
endmodule
bind ppl_position_preset_and_latch ppl_monitor mon (.clk(clk), .reset_n(reset_n), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .din(din));
